// ---- logic/swc_codec.v ----
// Scalable wideband speech codec: encoder and decoder datapaths.
// Assumes samples arrive synchronous to sys_clk_i with valid strobes and
// that the far party supplies the active mode outside the stream.
`timescale 1ns/1ps
`include "swc_defines.vh"
module swc_codec #(
    parameter FIFO_DEPTH = 8
) (
    // Clock and reset
    input wire sys_clk_i,
    input wire rst_i,
    // Mode, held outside the stream
    input wire [1:0] mode_i,
    // Encoder audio input, 16 kHz
    input wire enc_valid_i,
    input wire signed [15:0] enc_sample_i,
    // Encoder stream output
    output reg enc_byte_valid_o,
    input wire enc_byte_ready_i,
    output reg [7:0] enc_byte_o,
    output reg enc_frame_end_o,
    // Decoder stream input
    input wire dec_byte_valid_i,
    output reg dec_byte_ready_o,
    input wire [7:0] dec_byte_i,
    input wire dec_frame_erased_i,
    // Decoder audio output
    output reg dec_valid_o,
    output reg signed [15:0] dec_sample_o,
    output reg dec_wideband_o
);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // layer presence per mode
    function has_refine;
        input [1:0] m;
        begin
            has_refine = (m == `SWC_MODE_NB_REFINED) || (m == `SWC_MODE_FULL);
        end
    endfunction
    function has_high;
        input [1:0] m;
        begin
            has_high = (m == `SWC_MODE_WB_CORE) || (m == `SWC_MODE_FULL);
        end
    endfunction
    // Compress a sample to an 8-bit log-style code.
    function [7:0] compand;
        input signed [15:0] s;
        reg [15:0] mag;
        reg [2:0] ex;
        integer k;
        begin
            mag = s[15] ? (~s + 16'h0001) : s;
            ex = 3'h0;
            for (k = 8; k < 15; k = k + 1) begin
                if (mag[k]) begin
                    ex = k[2:0] - 3'h0;
                end
            end
            ex = (mag[14:8] == 7'h00) ? 3'h0 : ex + 3'h1;
            compand = {s[15], ex, mag[ex+4 -: 4]};
        end
    endfunction
    // Expand an 8-bit code back to a sample.
    function signed [15:0] expand;
        input [7:0] c;
        reg [15:0] mag;
        begin
            mag = {11'h000, 1'b1, c[3:0]} << c[6:4];
            expand = c[7] ? (~mag + 16'h0001) : mag;
        end
    endfunction
    // ------------------------------------------------------------------
    // Encoder front end
    // ------------------------------------------------------------------
    reg signed [15:0] hpf_prev_in;
    reg signed [19:0] hpf_out;
    reg signed [15:0] even_smp;
    reg phase;
    reg signed [16:0] low_band;
    reg signed [16:0] high_band;
    reg band_valid;
    wire signed [19:0] hpf_next;
    wire signed [15:0] hpf_s;
    assign hpf_next = hpf_out - (hpf_out >>> `SWC_HPF_SHIFT)
        + {{4{enc_sample_i[15]}}, enc_sample_i} - {{4{hpf_prev_in[15]}}, hpf_prev_in};
    assign hpf_s = hpf_next[15:0];
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hpf_prev_in <= 16'h0000;
            hpf_out <= 20'h00000;
            even_smp <= 16'h0000;
            phase <= 1'b0;
            low_band <= 17'h00000;
            high_band <= 17'h00000;
            band_valid <= 1'b0;
        end else begin
            band_valid <= 1'b0;
            if (enc_valid_i) begin
                hpf_prev_in <= enc_sample_i;
                hpf_out <= hpf_next;
                phase <= ~phase;
                if (!phase) begin
                    even_smp <= hpf_s;
                end else begin
                    low_band <= {even_smp[15], even_smp} + {hpf_s[15], hpf_s};
                    high_band <= {even_smp[15], even_smp} - {hpf_s[15], hpf_s};
                    band_valid <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Encoder layer assembly
    // ------------------------------------------------------------------
    reg [7:0] core_buf [0:`SWC_CORE_BYTES-1];
    reg [7:0] ref_buf [0:`SWC_ENH_BYTES-1];
    reg [7:0] hi_buf [0:`SWC_ENH_BYTES-1];
    reg [5:0] enc_idx;
    reg [15:0] hi_peak;
    reg [7:0] highband_norm_factor;
    reg [1:0] enc_mode;
    reg enc_busy;
    reg [1:0] enc_layer;
    reg [5:0] enc_pos;
    reg fifo_in_valid;
    reg [8:0] fifo_in_data;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [8:0] fifo_out_data;
    wire [7:0] core_code;
    wire [15:0] hi_abs;
    wire signed [15:0] core_exp = expand(core_code);
    assign core_code = compand(low_band[16:1]);
    assign hi_abs = high_band[16] ? (~high_band[16:1] + 16'h0001) : high_band[16:1];
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            enc_idx <= 6'h00;
            hi_peak <= 16'h0000;
            highband_norm_factor <= 8'h00;
            enc_mode <= `SWC_MODE_CORE_ONLY;
            enc_busy <= 1'b0;
            enc_layer <= 2'h0;
            enc_pos <= 6'h00;
            fifo_in_valid <= 1'b0;
            fifo_in_data <= 9'h000;
        end else begin
            if (band_valid) begin
                core_buf[enc_idx] <= core_code;
                if (enc_idx[1:0] == 2'h0) begin
                    ref_buf[enc_idx[5:2]] <= low_band[7:0] ^ core_exp[7:0];
                    // coarse spectral term, magnitude high byte without norm factor
                    hi_buf[enc_idx[5:2]] <= hi_abs[15:8];
                end
                hi_peak <= (hi_abs > hi_peak) ? hi_abs : hi_peak;
                if (enc_idx == `SWC_CORE_BYTES - 1) begin
                    enc_idx <= 6'h00;
                    highband_norm_factor <= hi_peak[15:8];
                    hi_peak <= 16'h0000;
                    // mode latched per frame from outside
                    enc_mode <= mode_i;
                    enc_busy <= 1'b1;
                    enc_layer <= 2'h0;
                    enc_pos <= 6'h00;
                end else begin
                    enc_idx <= enc_idx + 6'h01;
                end
            end
            if (fifo_in_valid && fifo_in_ready) begin
                fifo_in_valid <= 1'b0;
            end
            if (enc_busy && (!fifo_in_valid || fifo_in_ready)) begin
                fifo_in_valid <= 1'b1;
                case (enc_layer)
                    2'h0: fifo_in_data <= {1'b0, core_buf[enc_pos]};
                    2'h1: fifo_in_data <= {1'b0, ref_buf[enc_pos[3:0]]};
                    2'h2: fifo_in_data <= {1'b0, (enc_pos == 6'h00) ?
                        highband_norm_factor : hi_buf[enc_pos[3:0]]};
                    default: fifo_in_data <= 9'h000;
                endcase
                if ((enc_layer == 2'h0 && enc_pos == `SWC_CORE_BYTES - 1) ||
                    (enc_layer != 2'h0 && enc_pos == `SWC_ENH_BYTES - 1)) begin
                    enc_pos <= 6'h00;
                    if (enc_layer == 2'h0 && has_refine(enc_mode)) begin
                        enc_layer <= 2'h1;
                    end else if (enc_layer != 2'h2 && has_high(enc_mode)) begin
                        enc_layer <= 2'h2;
                    end else begin
                        enc_busy <= 1'b0;
                        fifo_in_data[8] <= 1'b1;
                    end
                end else begin
                    enc_pos <= enc_pos + 6'h01;
                end
            end
        end
    end

    swc_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH), .AW(3)) u_fifo (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(fifo_in_data),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(!enc_byte_valid_o || enc_byte_ready_i),
        .out_data_o(fifo_out_data)
    );

    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            enc_byte_valid_o <= 1'b0;
            enc_byte_o <= 8'h00;
            enc_frame_end_o <= 1'b0;
        end else if (!enc_byte_valid_o || enc_byte_ready_i) begin
            enc_byte_valid_o <= fifo_out_valid;
            enc_byte_o <= fifo_out_data[7:0];
            enc_frame_end_o <= fifo_out_valid && fifo_out_data[8];
        end
    end

    // ------------------------------------------------------------------
    // Decoder
    // ------------------------------------------------------------------
    reg [1:0] dec_mode;
    reg [1:0] dec_layer;
    reg [5:0] dec_pos;
    reg [7:0] dcore [0:`SWC_CORE_BYTES-1];
    reg [7:0] dref [0:`SWC_ENH_BYTES-1];
    reg [7:0] dhi [0:`SWC_ENH_BYTES-1];
    reg [7:0] dec_norm;
    reg play;
    reg [6:0] play_idx;
    reg signed [15:0] last_lb;
    reg signed [15:0] last_hb;
    reg [1:0] dec_play_mode;
    reg erased;
    wire [5:0] pi;
    wire signed [15:0] lb_core;
    wire signed [15:0] lb_val;
    wire signed [15:0] hb_val;
    wire signed [16:0] syn;
    wire signed [15:0] gated;
    wire [15:0] syn_abs;
    assign pi = play_idx[6:1];
    assign lb_core = erased ? (last_lb >>> 1) : expand(dcore[pi]);
    assign lb_val = lb_core + ((has_refine(dec_play_mode) && !erased) ?
        {{8{dref[pi[5:2]][7]}}, dref[pi[5:2]]} : 16'h0000);
    // inverse spectral step with the norm byte subtracted
    // high band concealed on its own
    assign hb_val = !has_high(dec_play_mode) ? 16'h0000 :
        erased ? (last_hb >>> 1) :
        (dhi[pi[5:2]] == 8'h00) ? 16'h0000 :
        $signed({1'b0, dhi[pi[5:2]][6:0], 8'h00}) - $signed({8'h00, dec_norm});
    assign syn = play_idx[0] ? ({lb_val[15], lb_val} - {hb_val[15], hb_val}) :
        ({lb_val[15], lb_val} + {hb_val[15], hb_val});
    assign syn_abs = syn[16] ? (~syn[16:1] + 16'h0001) : syn[16:1];
    assign gated = (syn_abs < `SWC_GATE_LEVEL) ? 16'h0000 : syn[16:1];
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dec_mode <= `SWC_MODE_CORE_ONLY;
            dec_layer <= 2'h0;
            dec_pos <= 6'h00;
            dec_norm <= 8'h00;
            play <= 1'b0;
            play_idx <= 7'h00;
            last_lb <= 16'h0000;
            last_hb <= 16'h0000;
            dec_play_mode <= `SWC_MODE_CORE_ONLY;
            erased <= 1'b0;
            dec_byte_ready_o <= 1'b0;
            dec_valid_o <= 1'b0;
            dec_sample_o <= 16'h0000;
            dec_wideband_o <= 1'b0;
        end else begin
            dec_byte_ready_o <= !play;
            dec_valid_o <= 1'b0;
            if (dec_layer == 2'h0 && dec_pos == 6'h00) begin
                dec_mode <= mode_i;
            end
            if (!play && dec_frame_erased_i) begin
                erased <= 1'b1;
                dec_play_mode <= mode_i;
                play <= 1'b1;
                play_idx <= 7'h00;
                dec_layer <= 2'h0;
                dec_pos <= 6'h00;
                dec_byte_ready_o <= 1'b0;
            end else if (!play && dec_byte_valid_i && dec_byte_ready_o) begin
                case (dec_layer)
                    2'h0: dcore[dec_pos] <= dec_byte_i;
                    2'h1: dref[dec_pos[3:0]] <= dec_byte_i;
                    2'h2: begin
                        if (dec_pos == 6'h00) begin
                            dec_norm <= dec_byte_i;
                        end
                        dhi[dec_pos[3:0]] <= (dec_pos == 6'h00) ? 8'h00 : dec_byte_i;
                    end
                    default: dec_pos <= 6'h00;
                endcase
                if ((dec_layer == 2'h0 && dec_pos == `SWC_CORE_BYTES - 1) ||
                    (dec_layer != 2'h0 && dec_pos == `SWC_ENH_BYTES - 1)) begin
                    dec_pos <= 6'h00;
                    if (dec_layer == 2'h0 && has_refine(dec_mode)) begin
                        dec_layer <= 2'h1;
                    end else if (dec_layer != 2'h2 && has_high(dec_mode)) begin
                        dec_layer <= 2'h2;
                    end else begin
                        dec_layer <= 2'h0;
                        erased <= 1'b0;
                        dec_play_mode <= dec_mode;
                        play <= 1'b1;
                        play_idx <= 7'h00;
                        dec_byte_ready_o <= 1'b0;
                    end
                end else begin
                    dec_pos <= dec_pos + 6'h01;
                end
            end
            if (play) begin
                dec_valid_o <= has_high(dec_play_mode) || !play_idx[0];
                // narrowband modes emit every other sample
                dec_sample_o <= has_high(dec_play_mode) ? gated :
                    ((lb_val < 16'sh0040) && (lb_val > -16'sh0040) ? 16'h0000 : lb_val);
                dec_wideband_o <= has_high(dec_play_mode);
                if (play_idx[0]) begin
                    last_lb <= lb_val;
                    last_hb <= hb_val;
                end
                if (play_idx == `SWC_WB_SAMPLES - 1) begin
                    play <= 1'b0;
                end else begin
                    play_idx <= play_idx + 7'h01;
                end
            end
        end
    end
endmodule // swc_codec

// ---- logic/swc_defines.vh ----
// Shared constants for the scalable wideband speech codec datapath.
// Assumes the includer needs frame layout, mode codes and filter constants.
`ifndef SWC_DEFINES_VH
`define SWC_DEFINES_VH
// Mode codes.
`define SWC_MODE_CORE_ONLY 2'h0
`define SWC_MODE_NB_REFINED 2'h1
`define SWC_MODE_WB_CORE 2'h2
`define SWC_MODE_FULL 2'h3
// Frame layout in bytes: 5 ms frame, 40 core codes, 10 bytes per enhancement layer.
`define SWC_FRAME_MS 5
`define SWC_CORE_BYTES 40
`define SWC_ENH_BYTES 10
`define SWC_WB_SAMPLES 80
// Pre-filter pole 0.984375 = 63/64, as a shift of 6.
`define SWC_HPF_SHIFT 6
// Noise gate threshold on output magnitude.
`define SWC_GATE_LEVEL 16'h0040
`endif

// ---- logic/swc_fifo.v ----
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
module swc_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // Clock and reset
    input wire sys_clk_i,
    input wire rst_i,
    // Write side
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    // Read side
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire do_wr;
    wire do_rd;
    assign in_ready_o = (count != DEPTH[AW:0]);
    assign out_valid_o = (count != {(AW+1){1'b0}});
    assign out_data_o = mem[rd_ptr];
    assign do_wr = in_valid_i && in_ready_o;
    assign do_rd = out_valid_o && out_ready_i;
    always @(posedge sys_clk_i) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data_i;
        end
    end
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count <= count + 1'b1;
            end else if (do_rd && !do_wr) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // swc_fifo

// ---- tb/swc_codec_checker.sv ----
// Port-timing checker for the speech codec.
// Assumes it is bound to swc_codec and sees only its ports.
`timescale 1ns/1ps
module swc_codec_checker (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Watched ports
    input wire logic enc_byte_valid_o,
    input wire logic enc_byte_ready_i,
    input wire logic [7:0] enc_byte_o,
    input wire logic enc_frame_end_o,
    input wire logic dec_byte_ready_o,
    input wire logic dec_valid_o,
    input wire logic signed [15:0] dec_sample_o,
    input wire logic dec_wideband_o
);
    // ----------------------------------------
    // Helper logic and sequences
    // ----------------------------------------
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    logic [6:0] nbytes;
    wire take = enc_byte_valid_o && enc_byte_ready_i;
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) nbytes <= 7'h00;
        else if (take) nbytes <= enc_frame_end_o ? 7'h00 : nbytes + 7'h01;
    end
    sequence s_wb_start; $rose(dec_valid_o) && dec_wideband_o; endsequence
    sequence s_wb_run; dec_valid_o [*8]; endsequence
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_reset_quiet: assert property (disable iff (1'b0)
        rst_i |-> !enc_byte_valid_o && !dec_valid_o && !dec_byte_ready_o)
        else $error("outputs active in reset");
    a_byte_hold: assert property (enc_byte_valid_o && !enc_byte_ready_i |=>
        enc_byte_valid_o && $stable(enc_byte_o) && $stable(enc_frame_end_o))
        else $error("stream byte changed before it was taken");
    a_frame_len: assert property (take && enc_frame_end_o |->
        nbytes == 7'h27 || nbytes == 7'h31 || nbytes == 7'h3B)
        else $error("frame length wrong");
    a_play_refuse: assert property (dec_valid_o |-> !dec_byte_ready_o)
        else $error("bytes accepted during playout");
    a_gate_floor: assert property (dec_valid_o |-> dec_sample_o == 16'sh0000 ||
        dec_sample_o >= 16'sh0040 || dec_sample_o <= -16'sh0040)
        else $error("sample below gate level passed");
    a_wb_burst: assert property (s_wb_start |-> s_wb_run)
        else $error("wideband samples not back to back");
    a_nb_spacing: assert property (dec_valid_o && !dec_wideband_o |=> !dec_valid_o)
        else $error("narrowband samples too close");
    a_rate_steady: assert property (dec_valid_o ##1 dec_valid_o |->
        $stable(dec_wideband_o))
        else $error("output rate changed in a frame");
endmodule // swc_codec_checker
bind swc_codec swc_codec_checker i_swc_codec_checker (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .enc_byte_valid_o(enc_byte_valid_o), .enc_byte_ready_i(enc_byte_ready_i),
    .enc_byte_o(enc_byte_o), .enc_frame_end_o(enc_frame_end_o),
    .dec_byte_ready_o(dec_byte_ready_o), .dec_valid_o(dec_valid_o),
    .dec_sample_o(dec_sample_o), .dec_wideband_o(dec_wideband_o));

// ---- tb/swc_net_model.sv ----
// Packet link model: sinks the encoder stream and measures each frame.
// Assumes the bench raises stall_i to make the sink take every other cycle.
`timescale 1ns/1ps
module swc_net_model (
    // Clock and reset
    input wire sys_clk_i,
    input wire rst_i,
    // Stream from the encoder
    input wire stall_i,
    input wire byte_valid_i,
    input wire frame_end_i,
    output wire ready_o,
    // Frame results
    output reg [6:0] frame_len_o,
    output reg [7:0] frame_cnt_o
);
    reg phase;
    reg [6:0] count;
    assign ready_o = !stall_i || phase;
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase <= 1'b0;
            count <= 7'h00;
            frame_len_o <= 7'h00;
            frame_cnt_o <= 8'h00;
        end else begin
            phase <= ~phase;
            if (byte_valid_i && ready_o) begin
                count <= frame_end_i ? 7'h00 : count + 7'h01;
                if (frame_end_i) begin
                    frame_len_o <= count + 7'h01;
                    frame_cnt_o <= frame_cnt_o + 8'h01;
                end
            end
        end
    end
endmodule // swc_net_model

// ---- tb/test_scalable_wideband_speech_codec.sv ----
// Self-checking bench for the speech codec.
// Assumes the link model and the checker are compiled with it.
`timescale 1ns/1ps
`include "swc_defines.vh"
`define SWC_CHK(got, exp) begin n_tests = n_tests + 1; if ((got) !== (exp)) begin \
    failures = failures + 1; $display("mismatch at %0t: value differs", $time); end end
module test_scalable_wideband_speech_codec;
    reg sys_clk_i = 1'b0;
    reg rst_i = 1'b0;
    reg [1:0] mode_i = 2'h0;
    reg enc_valid_i = 1'b0;
    reg signed [15:0] enc_sample_i = 16'h0000;
    reg dec_byte_valid_i = 1'b0;
    reg [7:0] dec_byte_i = 8'h00;
    reg dec_frame_erased_i = 1'b0;
    reg stall = 1'b0;
    wire enc_byte_valid_o, enc_byte_ready_i, enc_frame_end_o, dec_byte_ready_o;
    wire dec_valid_o, dec_wideband_o;
    wire [7:0] enc_byte_o;
    wire signed [15:0] dec_sample_o;
    wire [6:0] frame_len;
    wire [7:0] frame_cnt;
    integer failures = 0;
    integer n_tests = 0;
    integer s0, s1, m;
    always #25 sys_clk_i = ~sys_clk_i;
    swc_codec #(.FIFO_DEPTH(8)) i_swc_codec (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .mode_i(mode_i), .enc_valid_i(enc_valid_i), .enc_sample_i(enc_sample_i),
        .enc_byte_valid_o(enc_byte_valid_o), .enc_byte_ready_i(enc_byte_ready_i),
        .enc_byte_o(enc_byte_o), .enc_frame_end_o(enc_frame_end_o),
        .dec_byte_valid_i(dec_byte_valid_i), .dec_byte_ready_o(dec_byte_ready_o),
        .dec_byte_i(dec_byte_i), .dec_frame_erased_i(dec_frame_erased_i),
        .dec_valid_o(dec_valid_o), .dec_sample_o(dec_sample_o),
        .dec_wideband_o(dec_wideband_o));
    swc_net_model i_swc_net_model (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .stall_i(stall),
        .byte_valid_i(enc_byte_valid_o), .frame_end_i(enc_frame_end_o),
        .ready_o(enc_byte_ready_i), .frame_len_o(frame_len), .frame_cnt_o(frame_cnt));
    // ----------------------------------------
    // Scenario tasks
    // ----------------------------------------
    task wrap_up;
        begin
            if (failures == 0 && n_tests > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    task enc_frame(input [1:0] md, input st);
        integer i;
        reg [7:0] c0;
        begin
            c0 = frame_cnt;
            mode_i <= md;
            stall <= st;
            for (i = 0; i < 80; i = i + 1) begin
                @(posedge sys_clk_i);
                enc_valid_i <= 1'b1;
                enc_sample_i <= i[15:0] * 16'h0199;
                @(posedge sys_clk_i);
                enc_valid_i <= 1'b0;
                enc_sample_i <= ~enc_sample_i;
            end
            for (i = 0; i < 400 && frame_cnt == c0; i = i + 1) @(posedge sys_clk_i);
            `SWC_CHK(frame_cnt, c0 + 8'h01)
            `SWC_CHK(frame_len, `SWC_CORE_BYTES + (md[0] ? `SWC_ENH_BYTES : 0) + (md[1] ? `SWC_ENH_BYTES : 0))
        end
    endtask
    task play(input [1:0] md, output integer sum);
        integer i, cnt;
        begin
            cnt = 0;
            sum = 0;
            // Outputs are looked at mid-cycle, where they are settled.
            for (i = 0; i < 200; i = i + 1) begin
                @(negedge sys_clk_i);
                if (dec_valid_o === 1'b1) begin
                    cnt = cnt + 1;
                    sum = sum + dec_sample_o;
                    `SWC_CHK(dec_wideband_o, md[1])
                end
            end
            `SWC_CHK(cnt, md[1] ? `SWC_WB_SAMPLES : 40)
            @(posedge sys_clk_i);
        end
    endtask
    task dec_frame(input [1:0] md, input [7:0] core, input [7:0] lay, output integer sum);
        integer i, k, n;
        begin
            mode_i <= md;
            @(posedge sys_clk_i);
            n = `SWC_CORE_BYTES + (md[0] ? `SWC_ENH_BYTES : 0) + (md[1] ? `SWC_ENH_BYTES : 0);
            for (i = 0; i < n; i = i + 1) begin
                dec_byte_valid_i <= 1'b1;
                dec_byte_i <= (i < `SWC_CORE_BYTES) ? core : lay;
                // Hold the byte until ready is seen high ahead of the taking edge.
                @(negedge sys_clk_i);
                for (k = 0; k < 300 && dec_byte_ready_o !== 1'b1; k = k + 1)
                    @(negedge sys_clk_i);
                @(posedge sys_clk_i);
            end
            dec_byte_valid_i <= 1'b0;
            dec_byte_i <= ~dec_byte_i;
            play(md, sum);
        end
    endtask
    task erase(input [1:0] md);
        integer s;
        begin
            mode_i <= md;
            @(posedge sys_clk_i);
            dec_frame_erased_i <= 1'b1;
            @(posedge sys_clk_i);
            dec_frame_erased_i <= 1'b0;
            play(md, s);
        end
    endtask
    task zero_layers;
        begin
            dec_frame(2'h0, 8'h35, 8'h00, s0);
            dec_frame(2'h0, 8'h35, 8'h00, s0);
            dec_frame(2'h1, 8'h35, 8'h00, s1);
            `SWC_CHK(s1, s0)
            dec_frame(2'h2, 8'h35, 8'h00, s0);
            dec_frame(2'h2, 8'h35, 8'h00, s0);
            dec_frame(2'h3, 8'h35, 8'h00, s1);
            `SWC_CHK(s1, s0)
        end
    endtask
    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        rst_i <= 1'b1;
        repeat (16) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        for (m = 0; m < 4; m = m + 1) enc_frame(m[1:0], m[0]);
        for (m = 0; m < 4; m = m + 1) dec_frame(m[1:0], 8'hC3, 8'h5A, s0);
        zero_layers;
        erase(2'h1);
        erase(2'h3);
        wrap_up;
    end
    initial begin
        #1000000;
        failures = failures + 1;
        wrap_up;
    end
endmodule // test_scalable_wideband_speech_codec
